// [hw/kef_top.sv]
// kef_top: keypad event queue with AHB-Lite register slave
// assumes debounced matrix key events and plain-input levels on clk
//
// Overview of operation
// - matrix key code is row*10 plus column plus one
// - row inputs 97-104, column inputs 105-114
// - plain inputs share the matrix event path
// - active edge of plain input queues press
// - opposite level then queues a release
// - event byte is press bit plus code
// - locked with lock mode set drops inputs
// - bit 6 of lock register locks keypad
// - queue holds up to ten events
// - selected matrix lines and enabled inputs outside the matrix selection report
// - count readable in bits 3:0 at 0x03
// - event read pops oldest and shifts down
// - empty queue reads zero count and event
// - status flags mark matrix or input event
// - write one clears only that flag
// - push into full queue sets overflow flag
// - overflow with enable drives interrupt low
// - policy one drops oldest, zero drops new
`timescale 1ns/10ps
`default_nettype none
module kef_top (
    input  wire logic        clk,
    input  wire logic        reset_n,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // matrix scanner event: row 0..7, column 0..9, press level
    input  wire logic        key_valid,
    input  wire logic [2:0]  key_row,
    input  wire logic [3:0]  key_col,
    input  wire logic        key_press,
    // plain inputs, rows 0..7 then columns 0..9
    input  wire logic [17:0] plain_input,
    // open-drain interrupt
    output logic             irq_n_o,
    output logic             irq_n_oe
);
    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0]  cfg_ff,    nxt_cfg;
    logic [7:0]  stat_ff,   nxt_stat;
    logic        lock_ff,   nxt_lock;
    logic [17:0] msel_ff,   nxt_msel;
    logic [17:0] pen_ff,    nxt_pen;
    logic [17:0] pol_ff,    nxt_pol;
    logic [31:0] rdata_ff,  nxt_rdata;
    logic        irq_ff,    nxt_irq;
    // address phase capture
    logic        wr_ph_ff,  nxt_wr_ph;
    logic [11:0] wr_addr_ff, nxt_wr_addr;

    logic [17:0] pin_req, pin_ack;
    logic [17:0][7:0] pin_code;
    logic [7:0]  q_head;
    logic [3:0]  q_count;
    logic        q_ovf;
    logic        pop;
    logic        rd_go;
    logic [7:0]  rd_idx;
    logic [7:0]  wr_idx;
    logic        key_ok;
    logic        pin_drop;
    logic        ev_stored;
    logic [6:0]  key_code;
    logic        sel_pin;
    logic [4:0]  pin_sel;

    kef_evt_if evt ();

    ////////////////////////////////////////////////////////////////////////
    // plain-input edge detection
    kef_pin_events u_pins (
        .clk         (clk),
        .reset_n     (reset_n),
        .lines       (plain_input),
        .enables     (pen_ff & ~msel_ff),
        .active_high (pol_ff),
        .ack         (pin_ack),
        .req         (pin_req),
        .code        (pin_code)
    );

    ////////////////////////////////////////////////////////////////////////
    // event queue
    kef_queue u_queue (
        .clk             (clk),
        .reset_n         (reset_n),
        .evt             (evt),
        .pop             (pop),
        .policy_push_out (cfg_ff[kef_pkg::CFG_OVF_POLICY]),
        .head            (q_head),
        .count           (q_count),
        .overflow        (q_ovf)
    );

    ////////////////////////////////////////////////////////////////////////
    // event source arbitration; matrix first, else lowest pending input
    assign key_code = 7'(key_row) * 7'd10 + 7'(key_col) + 7'h01;
    assign key_ok   = key_valid && !lock_ff
                      && msel_ff[key_row] && msel_ff[kef_pkg::ROWS + 5'(key_col)];
    assign pin_drop = lock_ff && cfg_ff[kef_pkg::CFG_PIN_LOCK_MD];
    // a push counts as stored unless a full queue drops it
    assign ev_stored = evt.push && !(q_ovf && !cfg_ff[kef_pkg::CFG_OVF_POLICY]);

    always_comb begin
        sel_pin = 1'b0;
        pin_sel = 5'h00;
        for (int i = kef_pkg::LINES - 1; i >= 0; i--) begin
            if (pin_req[i]) begin
                sel_pin = 1'b1;
                pin_sel = 5'(i);
            end
        end
    end

    // one push per cycle; dropped inputs are acknowledged and lost
    always_comb begin
        pin_ack  = '0;
        evt.push = 1'b0;
        evt.data = 8'h00;
        if (key_ok) begin
            evt.push = 1'b1;
            evt.data = {key_press, key_code};
        end else if (sel_pin) begin
            pin_ack[pin_sel] = 1'b1;
            evt.push = !pin_drop;
            evt.data = pin_code[pin_sel];
        end
        if (pin_drop) begin
            pin_ack = pin_req;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite: writes commit in data phase, reads decoded in address phase
    assign rd_go  = hsel && hready && htrans[1] && !hwrite;
    // addresses beyond the map fold to an unused index, never alias
    assign rd_idx = (haddr[11:10] == 2'b00) ? haddr[9:2] : 8'hff;
    assign wr_idx = (wr_addr_ff[11:10] == 2'b00) ? wr_addr_ff[9:2] : 8'hff;
    assign pop    = rd_go && (rd_idx == kef_pkg::IDX_EVENT);

    always_comb begin
        nxt_wr_ph   = hsel && hready && htrans[1] && hwrite;
        nxt_wr_addr = nxt_wr_ph ? haddr : wr_addr_ff;
        nxt_rdata   = 32'h0000_0000;
        if (rd_go) begin
            case (rd_idx)
                kef_pkg::IDX_CFG:        nxt_rdata = {24'h000000, cfg_ff};
                kef_pkg::IDX_STATUS:     nxt_rdata = {24'h000000, stat_ff};
                kef_pkg::IDX_LOCK_CNT:   nxt_rdata = {24'h000000, 1'b0, lock_ff, 2'b00, q_count};
                kef_pkg::IDX_EVENT:      nxt_rdata = {24'h000000, q_head};
                kef_pkg::IDX_MATRIX_SEL: nxt_rdata = {14'h0000, msel_ff};
                kef_pkg::IDX_PIN_EN:     nxt_rdata = {14'h0000, pen_ff};
                kef_pkg::IDX_PIN_POL:    nxt_rdata = {14'h0000, pol_ff};
                kef_pkg::IDX_KEY_IN:     nxt_rdata = {14'h0000, plain_input};
                default:                 nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    // register writes and status flags
    always_comb begin
        nxt_cfg  = cfg_ff;
        nxt_lock = lock_ff;
        nxt_msel = msel_ff;
        nxt_pen  = pen_ff;
        nxt_pol  = pol_ff;
        nxt_stat = stat_ff;
        if (wr_ph_ff) begin
            case (wr_idx)
                kef_pkg::IDX_CFG:        nxt_cfg  = hwdata[7:0];
                kef_pkg::IDX_STATUS:     nxt_stat = stat_ff & ~hwdata[7:0];
                kef_pkg::IDX_LOCK_CNT:   nxt_lock = hwdata[kef_pkg::LOCK_BIT];
                kef_pkg::IDX_MATRIX_SEL: nxt_msel = hwdata[17:0];
                kef_pkg::IDX_PIN_EN:     nxt_pen  = hwdata[17:0];
                kef_pkg::IDX_PIN_POL:    nxt_pol  = hwdata[17:0];
                default:                 nxt_cfg  = cfg_ff;
            endcase
        end
        // hardware sets win over a same-cycle clear
        if (ev_stored && key_ok) begin
            nxt_stat[kef_pkg::ST_MATRIX_EVT] = 1'b1;
        end
        if (ev_stored && !key_ok) begin
            nxt_stat[kef_pkg::ST_PIN_EVT] = 1'b1;
        end
        if (q_ovf) begin
            nxt_stat[kef_pkg::ST_OVERFLOW] = 1'b1;
        end
        nxt_irq = nxt_stat[kef_pkg::ST_OVERFLOW] && nxt_cfg[kef_pkg::CFG_OVF_IRQ_EN];
    end

    // register state
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cfg_ff     <= kef_pkg::CFG_RST;
            stat_ff    <= 8'h00;
            lock_ff    <= 1'b0;
            msel_ff    <= 18'h00000;
            pen_ff     <= 18'h00000;
            pol_ff     <= 18'h00000;
            rdata_ff   <= 32'h0000_0000;
            irq_ff     <= 1'b0;
            wr_ph_ff   <= 1'b0;
            wr_addr_ff <= 12'h000;
        end else begin
            cfg_ff     <= nxt_cfg;
            stat_ff    <= nxt_stat;
            lock_ff    <= nxt_lock;
            msel_ff    <= nxt_msel;
            pen_ff     <= nxt_pen;
            pol_ff     <= nxt_pol;
            rdata_ff   <= nxt_rdata;
            irq_ff     <= nxt_irq;
            wr_ph_ff   <= nxt_wr_ph;
            wr_addr_ff <= nxt_wr_addr;
        end
    end

    // outputs straight from flops; zero-wait OKAY slave
    assign hrdata    = rdata_ff;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign irq_n_o   = 1'b0;
    assign irq_n_oe  = irq_ff;
endmodule // kef_top
`default_nettype wire

// [hw/kef_pkg.sv]
// kef_pkg: shared constants for the keypad event queue
// assumes an AHB-Lite slave with 32-bit data, one word per register
package kef_pkg;
    // register indices; the byte address is four times the index
    localparam logic [7:0] IDX_CFG        = 8'h01;
    localparam logic [7:0] IDX_STATUS     = 8'h02;
    localparam logic [7:0] IDX_LOCK_CNT   = 8'h03;
    localparam logic [7:0] IDX_EVENT      = 8'h04;
    localparam logic [7:0] IDX_MATRIX_SEL = 8'h05;
    localparam logic [7:0] IDX_PIN_EN     = 8'h06;
    localparam logic [7:0] IDX_PIN_POL    = 8'h07;
    localparam logic [7:0] IDX_KEY_IN     = 8'h08;
    localparam int ADDR_W = 12;
    // cfg fields
    localparam int CFG_OVF_POLICY  = 0;
    localparam int CFG_OVF_IRQ_EN  = 1;
    localparam int CFG_PIN_LOCK_MD = 2;
    localparam logic [7:0] CFG_RST = 8'h00;
    // status fields
    localparam int ST_MATRIX_EVT = 0;
    localparam int ST_PIN_EVT    = 1;
    localparam int ST_OVERFLOW   = 3;
    // lock/count fields
    localparam int LOCK_BIT = 6;
    // queue geometry and codes
    localparam int DEPTH   = 10;
    localparam int ROWS    = 8;
    localparam int COLS    = 10;
    localparam int LINES   = 18;
    localparam logic [6:0] ROW_PIN_BASE = 7'h61; // 97
    localparam logic [6:0] COL_PIN_BASE = 7'h69; // 105
    localparam logic [3:0] COUNT_FULL   = 4'ha;
endpackage

// [hw/kef_evt_if.sv]
// kef_evt_if: one event push from a source toward the queue
// assumes a single clock domain; push is a one-cycle pulse
`timescale 1ns/10ps
`default_nettype none
interface kef_evt_if;
    logic       push;
    logic [7:0] data;
    modport src (output push, output data);
    modport dst (input push, input data);
endinterface
`default_nettype wire

// [hw/kef_pin_events.sv]
// kef_pin_events: plain-input edge detection and event encoding
// assumes inputs already debounced and synchronous to clk
`timescale 1ns/10ps
`default_nettype none
module kef_pin_events (
    input  wire logic                        clk,
    input  wire logic                        reset_n,
    input  wire logic [kef_pkg::LINES-1:0]   lines,
    input  wire logic [kef_pkg::LINES-1:0]   enables,
    input  wire logic [kef_pkg::LINES-1:0]   active_high,
    input  wire logic [kef_pkg::LINES-1:0]   ack,
    output logic      [kef_pkg::LINES-1:0]   req,
    output logic      [kef_pkg::LINES-1:0][7:0] code
);
    logic [kef_pkg::LINES-1:0] prev_ff;
    logic [kef_pkg::LINES-1:0] nxt_prev;
    logic [kef_pkg::LINES-1:0] pend_ff;
    logic [kef_pkg::LINES-1:0] nxt_pend;
    logic [kef_pkg::LINES-1:0] kind_ff;
    logic [kef_pkg::LINES-1:0] nxt_kind;

    ////////////////////////////////////////////////////////////////////////
    // per-line edge capture; press on active edge, release on the opposite
    genvar g;
    generate
        for (g = 0; g < kef_pkg::LINES; g++) begin : g_line
            logic act_now;
            logic act_prev;
            assign act_now  = lines[g] ~^ active_high[g];
            assign act_prev = prev_ff[g] ~^ active_high[g];
            always_comb begin
                nxt_prev[g] = lines[g];
                nxt_pend[g] = pend_ff[g] & ~ack[g];
                nxt_kind[g] = kind_ff[g];
                if (enables[g] && (act_now != act_prev)) begin
                    nxt_pend[g] = 1'b1;
                    nxt_kind[g] = act_now;
                end
            end
            // row lines 97.., column lines 105..
            if (g < kef_pkg::ROWS) begin : g_row
                assign code[g] = {kind_ff[g], 7'(kef_pkg::ROW_PIN_BASE + 7'(g))};
            end else begin : g_col
                assign code[g] = {kind_ff[g], 7'(kef_pkg::COL_PIN_BASE + 7'(g - kef_pkg::ROWS))};
            end
        end
    endgenerate

    assign req = pend_ff;

    // edge state registers
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            prev_ff <= '0;
            pend_ff <= '0;
            kind_ff <= '0;
        end else begin
            prev_ff <= nxt_prev;
            pend_ff <= nxt_pend;
            kind_ff <= nxt_kind;
        end
    end
endmodule // kef_pin_events
`default_nettype wire

// [hw/kef_queue.sv]
// kef_queue: ten-byte shift queue with overflow policy
// assumes at most one push and one pop per cycle
`timescale 1ns/10ps
`default_nettype none
module kef_queue (
    input  wire logic       clk,
    input  wire logic       reset_n,
    kef_evt_if.dst          evt,
    input  wire logic       pop,
    input  wire logic       policy_push_out,
    output logic [7:0]      head,
    output logic [3:0]      count,
    output logic            overflow
);
    logic [kef_pkg::DEPTH-1:0][7:0] slot_ff;
    logic [kef_pkg::DEPTH-1:0][7:0] nxt_slot;
    logic [3:0]                     cnt_ff;
    logic [3:0]                     nxt_cnt;
    logic                           full;
    logic                           do_pop;
    logic [3:0]                     base;

    assign full     = (cnt_ff == kef_pkg::COUNT_FULL);
    assign do_pop   = pop && (cnt_ff != 4'h0);
    assign overflow = evt.push && full && !do_pop;
    assign head     = (cnt_ff == 4'h0) ? 8'h00 : slot_ff[0];
    assign count    = cnt_ff;

    ////////////////////////////////////////////////////////////////////////
    // shift down on pop or on push-out overflow, append at tail
    always_comb begin
        nxt_slot = slot_ff;
        nxt_cnt  = cnt_ff;
        base     = cnt_ff;
        if (do_pop || (overflow && policy_push_out)) begin
            for (int i = 0; i < kef_pkg::DEPTH - 1; i++) begin
                nxt_slot[i] = slot_ff[i+1];
            end
            nxt_slot[kef_pkg::DEPTH-1] = 8'h00;
            base = cnt_ff - 4'h1;
            nxt_cnt = cnt_ff - 4'h1;
        end
        if (evt.push && (!overflow || policy_push_out)) begin
            nxt_slot[base] = evt.data;
            nxt_cnt = base + 4'h1;
        end
    end

    // queue storage
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            slot_ff <= '0;
            cnt_ff  <= 4'h0;
        end else begin
            slot_ff <= nxt_slot;
            cnt_ff  <= nxt_cnt;
        end
    end
endmodule // kef_queue
`default_nettype wire

// [verif/kef_top_props.sv]
// kef_top_props: bus answer and interrupt checks on kef_top ports
// assumes one clock domain, bound to every kef_top instance
`timescale 1ns/10ps
`default_nettype none
module kef_top_props (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    input  wire logic        hreadyout,
    input  wire logic        hresp,
    input  wire logic        irq_n_o,
    input  wire logic        irq_n_oe
);
    logic        rd_ff;
    logic        wr_ff;
    logic        irq_en_ff;
    logic [11:0] a_ff;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////////////
    // data-phase tracking and shadow of the overflow irq enable
    always_ff @(posedge clk) begin
        rd_ff <= reset_n && hsel && hready && htrans[1] && !hwrite;
        wr_ff <= reset_n && hsel && hready && htrans[1] && hwrite;
        a_ff  <= haddr;
        if (!reset_n) begin
            irq_en_ff <= 1'b0;
        end else if (wr_ff && a_ff == 12'h004) begin
            irq_en_ff <= hwdata[kef_pkg::CFG_OVF_IRQ_EN];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // assertions
    AST_RESP_OKAY: assert property (hresp == 1'b0 && hreadyout == 1'b1)
        else $error("slave answer not zero-wait okay");
    AST_IDLE_ZERO: assert property (!rd_ff |-> hrdata == 32'h0)
        else $error("read data outside data phase");
    AST_EVT_FORMAT: assert property (rd_ff && a_ff == 12'h010 |->
        hrdata[31:8] == 24'h0 && (hrdata[7:0] == 8'h0 || hrdata[6:0] inside {[1:114]}))
        else $error("event byte malformed");
    AST_EMPTY_ZERO: assert property (rd_ff && a_ff == 12'h010 && hrdata[6:0] == 7'h0 |->
        hrdata[7] == 1'b0)
        else $error("empty event not zero");
    AST_COUNT_RANGE: assert property (rd_ff && a_ff == 12'h00c |->
        hrdata[3:0] <= 4'ha && hrdata[5:4] == 2'h0 && hrdata[31:7] == 25'h0)
        else $error("event count out of range");
    AST_STATUS_BITS: assert property (rd_ff && a_ff == 12'h008 |->
        hrdata[31:4] == 28'h0 && !hrdata[2])
        else $error("status reserved bit set");
    AST_UNMAPPED: assert property (rd_ff && a_ff > 12'h023 |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    AST_IRQ_GATED: assert property ($rose(irq_n_oe) |-> irq_en_ff || $past(irq_en_ff))
        else $error("interrupt without enable");
    AST_IRQ_PIN_LOW: assert property (irq_n_o == 1'b0)
        else $error("interrupt pin drives high");
    // main scenarios
    cover property (rd_ff && a_ff == 12'h010 && hrdata[7]);
    cover property ($rose(irq_n_oe));
    cover property (rd_ff && a_ff == 12'h00c && hrdata[3:0] == 4'ha);
endmodule // kef_top_props
bind kef_top kef_top_props kef_top_props_i (.clk(clk), .reset_n(reset_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq_n_o(irq_n_o),
    .irq_n_oe(irq_n_oe));
`default_nettype wire

// [verif/kef_host.sv]
// kef_host: host processor model, AHB-Lite master of single word transfers
// assumes tasks are entered right after a rising clock edge
`timescale 1ns/10ps
`default_nettype none
module kef_host (
    input  wire logic        clk,
    input  wire logic [31:0] hrdata,
    input  wire logic        hreadyout,
    output logic             hsel,
    output logic [11:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    ////////////////////////////////////////////////////////////////////////
    // idle bus at time zero
    initial begin
        hsel = 1'b0;
        haddr = 12'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    // bounded wait for hready at a rising edge
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge clk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 16) begin
                tb_kef_top.n_fail++;
                tb_kef_top.finish_test();
            end
            @(posedge clk);
        end
    endtask
    // address phase, then data phase; read data taken at its end
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= w ? wd : ~wd;
        wait_rdy();
        rd = hrdata;
        hwdata <= ~wd; // released data shows no stale value
    endtask
    // flag clears are written as ones
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        xfer(1'b1, a, d, x);
    endtask
    // one read of the register at address a, data returned in d
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        xfer(1'b0, a, 32'h0, d);
    endtask
endmodule // kef_host
`default_nettype wire

// [verif/tb_kef_top.sv]
// tb_kef_top: self-checking bench for the keypad event queue
// assumes kef_host as bus master and kef_top_props bound to the design
`timescale 1ns/10ps
`default_nettype none
module tb_kef_top;
    logic        clk = 1'b0;
    logic        reset_n;
    logic        key_valid;
    logic [2:0]  key_row;
    logic [3:0]  key_col;
    logic        key_press;
    logic [17:0] plain_input;
    logic        hsel;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        irq_n_o;
    logic        irq_n_oe;
    int          n_fail = 0;
    int          samples_checked = 0;
    // 100 MHz clock
    always #5 clk = ~clk;
    kef_host kef_host_i (.clk(clk), .hrdata(hrdata), .hreadyout(hreadyout), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    kef_top kef_top_i (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .key_valid(key_valid),
        .key_row(key_row), .key_col(key_col), .key_press(key_press),
        .plain_input(plain_input), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe));
    ////////////////////////////////////////////////////////////////////////
    // verdict and end of run
    task automatic finish_test();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // compare and report
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // read a register and compare
    task automatic rc(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] d;
        kef_host_i.rd(a, d);
        chk(d, e);
    endtask
    // one matrix event pulse
    task automatic key(input logic [2:0] r, input logic [3:0] c, input logic p);
        key_valid <= 1'b1;
        key_row <= r;
        key_col <= c;
        key_press <= p;
        @(posedge clk);
        key_valid <= 1'b0;
        @(posedge clk);
    endtask
    // plain input level change, settled before the next one
    task automatic pin(input logic [17:0] v);
        plain_input <= v;
        repeat (3) @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset();
        rc(12'h008, 32'h0);
        rc(12'h00c, 32'h0);
        rc(12'h010, 32'h0);
        rc(12'h004, 32'h0);
    endtask
    task automatic t_matrix();
        kef_host_i.wr(12'h014, 32'h3ffff);
        key(3'h0, 4'h0, 1'b1);
        key(3'h7, 4'h9, 1'b1);
        key(3'h3, 4'h1, 1'b0);
        rc(12'h00c, 32'h3);
        rc(12'h010, 32'h81);
        rc(12'h00c, 32'h2);
        rc(12'h010, 32'hd0);
        rc(12'h010, 32'h20);
        rc(12'h010, 32'h0);
        rc(12'h00c, 32'h0);
        rc(12'h008, 32'h1);
        kef_host_i.wr(12'h008, 32'h2);
        rc(12'h008, 32'h1);
        kef_host_i.wr(12'h008, 32'h1);
        rc(12'h008, 32'h0);
    endtask
    task automatic t_over(input logic p);
        kef_host_i.wr(12'h004, {30'h0, p, p});
        rc(12'h004, {30'h0, p, p});
        rc(12'h404, 32'h0);
        for (int i = 0; i < 11; i++) begin
            key(3'(i / 10), 4'(i % 10), 1'b1);
        end
        rc(12'h00c, 32'ha);
        rc(12'h008, 32'h9);
        chk({31'h0, irq_n_oe}, {31'h0, p});
        for (int i = 0; i < 10; i++) begin
            rc(12'h010, 32'h80 | (i + 1 + p));
        end
        kef_host_i.wr(12'h008, 32'h9);
        kef_host_i.wr(12'h004, 32'h0);
        chk({31'h0, irq_n_oe}, 32'h0);
    endtask
    task automatic t_plain();
        kef_host_i.wr(12'h014, 32'h0);
        kef_host_i.wr(12'h01c, 32'h1);
        kef_host_i.wr(12'h018, 32'h101);
        pin(18'h00101);
        pin(18'h00100);
        pin(18'h00000);
        pin(18'h00100);
        pin(18'h00102);
        pin(18'h00100);
        key(3'h0, 4'h0, 1'b1);
        rc(12'h020, 32'h100);
        rc(12'h00c, 32'h4);
        rc(12'h008, 32'h2);
        rc(12'h010, 32'he1);
        rc(12'h010, 32'h61);
        rc(12'h010, 32'he9);
        rc(12'h010, 32'h69);
        kef_host_i.wr(12'h008, 32'h2);
    endtask
    task automatic t_lock();
        kef_host_i.wr(12'h00c, 32'h40);
        rc(12'h00c, 32'h40);
        kef_host_i.wr(12'h004, 32'h4);
        pin(18'h00101);
        pin(18'h00100);
        rc(12'h00c, 32'h40);
        kef_host_i.wr(12'h004, 32'h0);
        pin(18'h00101);
        pin(18'h00100);
        rc(12'h00c, 32'h42);
        rc(12'h010, 32'he1);
        rc(12'h010, 32'h61);
        kef_host_i.wr(12'h00c, 32'h0);
        rc(12'h00c, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // reset, then the scenarios in turn
    initial begin
        reset_n = 1'b0;
        key_valid = 1'b0;
        key_row = 3'h0;
        key_col = 4'h0;
        key_press = 1'b0;
        plain_input = 18'h00100;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_matrix();
        t_over(1'b0);
        t_over(1'b1);
        t_plain();
        t_lock();
        finish_test();
    end
endmodule // tb_kef_top
`default_nettype wire
